// *** verilog/c8b_core.sv ***
// How it works
// - add-with-carry, six modes, opcodes A9..F9, 2/3/4/3/4/5 cycles.
// - subtract-with-borrow, opcodes A2..F2, lengths 2/2/3/1/2/3 bytes.
// - exclusive-or into accumulator, opcodes A8..F8, 2/3/4/3/4/5 cycles.
// - bit test A5..F5 sets flags only, accumulator unchanged.
// - opcode 23 branches if carry or zero set; 2 bytes, 3 cycles.
// - 24 branches on carry clear, 25 on carry set; aliases share encodings.
// - opcode 28 branches when half carry clear; 2 bytes, 3 cycles.
// - opcode 29 branches when half carry set; 2 bytes, 3 cycles.
// - opcode 2C branches when interrupt mask clear; 2 bytes, 3 cycles.
// - opcode 2D branches when interrupt mask set; 2 bytes, 3 cycles.
// - opcode 2E branches on interrupt line low level, not on pending latch.
// - opcode 2F branches on interrupt line high level; 2 bytes, 3 cycles.
// - add-with-carry sets half carry on carry from bit 3 to 4.
// - mask set blocks interrupts; requests stay pending until IRQ_ACK clears them.
`timescale 1ns/100ps
`include "c8b_params.svh"

module c8b_core
  import c8b_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // program and data memory, read data valid while MEM_RD is high
  output logic      [15:0] MEM_ADDR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  // interrupt line and acknowledge
  input  wire logic        IRQ_N,
  input  wire logic        IRQ_ACK,
  output logic             IRQ_REQ,
  // register loads from the rest of the core
  input  wire logic        LD_IDX_WR,
  input  wire logic        LD_CCR_WR,
  input  wire logic [7:0]  LD_DATA,
  // visible state
  output logic      [7:0]  ACC,
  output logic      [7:0]  IDX,
  output logic      [4:0]  CCR,
  output logic      [15:0] PC,
  output logic             INSTR_DONE,
  output logic             ILLEGAL
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    c8b_state_t st;
    logic [2:0]  cnt;
    logic [2:0]  total;
    logic [7:0]  opc;
    c8b_mode_t   mode;
    c8b_aop_t    aop;
    logic        is_br;
    logic        illegal;
    logic [7:0]  hi;
    logic [7:0]  opnd;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [4:0]  ccr;
    logic [15:0] addr;
    logic        rd;
    logic        done;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        lvl;
    logic        lvl_d;
    logic        pend;
    logic        irq_req;
  } c8b_core_t;

  c8b_core_t r;
  c8b_core_t n;

  logic [7:0]  alu_res;
  logic [4:0]  alu_ccr;
  logic [7:0]  opv;
  logic [15:0] tgt;
  logic        take;
  logic        fin;
  logic        br_ok;

  // ****************************************
  // decode and alu
  // ****************************************
  c8b_dec_if u_dif ();
  assign u_dif.opcode = MEM_RDATA;

  c8b_decode u_dec (
    .dif (u_dif.dec)
  );

  c8b_alu u_alu (
    .aop     (r.aop),
    .a       (r.acc),
    .m       (opv),
    .ccr_in  (r.ccr),
    .res     (alu_res),
    .ccr_out (alu_ccr)
  );

  // ****************************************
  // branch condition
  // ****************************************
  always_comb begin
    case (r.opc)
      `C8B_OP_LOWER_SAME:   br_ok = r.ccr[`C8B_CCR_C] | r.ccr[`C8B_CCR_Z];
      `C8B_OP_CARRY_CLEAR:  br_ok = ~r.ccr[`C8B_CCR_C];
      `C8B_OP_CARRY_SET:    br_ok = r.ccr[`C8B_CCR_C];
      `C8B_OP_HCARRY_CLEAR: br_ok = ~r.ccr[`C8B_CCR_H];
      `C8B_OP_HCARRY_SET:   br_ok = r.ccr[`C8B_CCR_H];
      `C8B_OP_MASK_CLEAR:   br_ok = ~r.ccr[`C8B_CCR_I];
      `C8B_OP_MASK_SET:     br_ok = r.ccr[`C8B_CCR_I];
      `C8B_OP_IRQ_LOW:      br_ok = ~r.lvl;
      `C8B_OP_IRQ_HIGH:     br_ok = r.lvl;
      default:              br_ok = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n      = r;
    n.done = 1'b0;
    n.rd   = 1'b0;
    n.cnt  = 3'(r.cnt + 3'd1);
    take   = 1'b0;
    fin    = 1'b0;
    // line passes three flops; a change counts once the last two agree
    n.s1    = IRQ_N;
    n.s2    = r.s1;
    n.s3    = r.s2;
    n.lvl_d = r.lvl;
    if (r.s2 == r.s3) begin
      n.lvl = r.s3;
    end
    // falling edge latched, gated by mask
    if (IRQ_ACK) begin
      n.pend = 1'b0;
    end
    if (r.lvl_d && !r.lvl) begin
      n.pend = 1'b1;
    end
    n.irq_req = r.pend & ~r.ccr[`C8B_CCR_I];
    case (r.st)
      ST_BOOT: begin
        n.addr = `C8B_PC_RST;
        n.rd   = 1'b1;
        n.pc   = 16'(`C8B_PC_RST + 16'h0001);
        n.cnt  = 3'd0;
        n.st   = ST_OP;
      end
      ST_OP: begin
        n.opc     = MEM_RDATA;
        n.mode    = u_dif.mode;
        n.aop     = u_dif.aop;
        n.is_br   = u_dif.is_br;
        n.total   = u_dif.cycles;
        n.illegal = ~u_dif.legal;
        if (!u_dif.legal) begin
          n.st = ST_PAD;
        end else if (u_dif.mode == M_IX) begin
          n.addr = {8'h00, r.idx};
          n.rd   = 1'b1;
          n.st   = ST_DATA;
        end else begin
          n.addr = r.pc;
          n.rd   = 1'b1;
          n.pc   = 16'(r.pc + 16'h0001);
          n.st   = ST_B1;
        end
      end
      ST_B1: begin
        case (r.mode)
          M_IMM, M_REL: take = 1'b1;
          M_DIR: begin
            n.addr = {8'h00, MEM_RDATA};
            n.rd   = 1'b1;
            n.st   = ST_DATA;
          end
          M_IX1: begin
            n.addr = {8'h00, MEM_RDATA} + {8'h00, r.idx};
            n.rd   = 1'b1;
            n.st   = ST_DATA;
          end
          default: begin
            n.hi   = MEM_RDATA;
            n.addr = r.pc;
            n.rd   = 1'b1;
            n.pc   = 16'(r.pc + 16'h0001);
            n.st   = ST_B2;
          end
        endcase
      end
      ST_B2: begin
        n.addr = {r.hi, MEM_RDATA} + ((r.mode == M_IX2) ? {8'h00, r.idx} : 16'h0000);
        n.rd   = 1'b1;
        n.st   = ST_DATA;
      end
      ST_DATA: take = 1'b1;
      default: take = 1'b0;
    endcase
    if (take) begin
      n.opnd = MEM_RDATA;
      n.st   = ST_PAD;
    end
    if ((take || r.st == ST_PAD) && r.cnt == 3'(r.total - 3'd1)) begin
      fin = 1'b1;
      if (!r.is_br && !r.illegal) begin
        n.acc = alu_res;
        n.ccr = alu_ccr;
      end
      n.addr = (r.is_br && br_ok) ? tgt : r.pc;
      n.rd   = 1'b1;
      n.pc   = 16'(n.addr + 16'h0001);
      n.done = 1'b1;
      n.cnt  = 3'd0;
      n.st   = ST_OP;
    end
    if (LD_IDX_WR) begin
      n.idx = LD_DATA;
    end
    if (LD_CCR_WR) begin
      n.ccr = LD_DATA[4:0];
    end
  end

  assign opv = take ? MEM_RDATA : r.opnd;
  assign tgt = r.pc + {{8{opv[7]}}, opv};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r         <= '0;
      r.st      <= ST_BOOT;
      r.mode    <= M_IMM;
      r.aop     <= AOP_ADC;
      r.total   <= `C8B_CYC_BAD;
      r.pc      <= `C8B_PC_RST;
      r.acc     <= `C8B_ACC_RST;
      r.idx     <= `C8B_IDX_RST;
      r.ccr     <= `C8B_CCR_RST;
      r.s1      <= 1'b1;
      r.s2      <= 1'b1;
      r.s3      <= 1'b1;
      r.lvl     <= 1'b1;
      r.lvl_d   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign MEM_ADDR   = r.addr;
  assign MEM_RD     = r.rd;
  assign IRQ_REQ    = r.irq_req;
  assign ACC        = r.acc;
  assign IDX        = r.idx;
  assign CCR        = r.ccr;
  assign PC         = r.pc;
  assign INSTR_DONE = r.done;
  assign ILLEGAL    = r.illegal;

  // ****************************************
  // checks
  // ****************************************
  logic [4:0] hsum;
  assign hsum = {1'b0, r.acc[3:0]} + {1'b0, opv[3:0]} + {4'h0, r.ccr[`C8B_CCR_C]};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_ADC_IMM: assert property (
    (r.st == ST_OP && MEM_RDATA == 8'hA9) |=> fin)
    else $error("immediate add-with-carry not done in 2 cycles");
  AST_SBC_EXT: assert property (
    (r.st == ST_OP && MEM_RDATA == 8'hC2) |=> !fin [*2] ##1 fin)
    else $error("extended subtract-with-borrow not done in 4 cycles");
  AST_EOR_IX2: assert property (
    (r.st == ST_OP && MEM_RDATA == 8'hD8) |=> !fin [*3] ##1 fin)
    else $error("16-bit indexed exclusive-or not done in 5 cycles");
  AST_BIT_ACC: assert property (
    (fin && !r.is_br && r.aop == AOP_BIT) |=> ACC == $past(ACC))
    else $error("bit test changed the accumulator");
  AST_BR_TIME: assert property (
    (r.st == ST_OP && u_dif.is_br) |=> !fin ##1 fin ##1 INSTR_DONE)
    else $error("branch not done in 3 cycles");
  AST_BLS_TGT: assert property (
    (fin && r.opc == 8'h23 && (CCR[`C8B_CCR_C] || CCR[`C8B_CCR_Z])) |=> MEM_ADDR == $past(tgt))
    else $error("lower-or-same branch missed its target");
  AST_IRQ_HIGH_FALL: assert property (
    (fin && r.opc == 8'h2E && r.lvl) |=> MEM_ADDR == $past(r.pc))
    else $error("line-low branch taken with line high");
  AST_HALF_CARRY: assert property (
    (fin && !r.is_br && !r.illegal && r.aop == AOP_ADC && !LD_CCR_WR)
      |=> CCR[`C8B_CCR_H] == $past(hsum[4]))
    else $error("half carry wrong after add-with-carry");
  AST_MASK_BLOCK: assert property (
    CCR[`C8B_CCR_I] |=> !IRQ_REQ)
    else $error("interrupt request passed while masked");

endmodule : c8b_core

// *** pkg/c8b_params.svh ***
`ifndef C8B_PARAMS_SVH
`define C8B_PARAMS_SVH

// ****************************************
// opcode rows (high nibble) per operand mode
// ****************************************
`define C8B_ROW_IMM 4'hA
`define C8B_ROW_DIR 4'hB
`define C8B_ROW_EXT 4'hC
`define C8B_ROW_IX  4'hF
`define C8B_ROW_IX1 4'hE
`define C8B_ROW_IX2 4'hD
`define C8B_ROW_REL 4'h2

// ****************************************
// opcode columns (low nibble) per operation
// ****************************************
`define C8B_LO_ADC 4'h9
`define C8B_LO_SBC 4'h2
`define C8B_LO_EOR 4'h8
`define C8B_LO_BIT 4'h5

// ****************************************
// relative branch opcodes
// ****************************************
`define C8B_OP_LOWER_SAME   8'h23
`define C8B_OP_CARRY_CLEAR  8'h24
`define C8B_OP_CARRY_SET    8'h25
`define C8B_OP_HCARRY_CLEAR 8'h28
`define C8B_OP_HCARRY_SET   8'h29
`define C8B_OP_MASK_CLEAR   8'h2C
`define C8B_OP_MASK_SET     8'h2D
`define C8B_OP_IRQ_LOW      8'h2E
`define C8B_OP_IRQ_HIGH     8'h2F

// ****************************************
// cycle counts per mode
// ****************************************
`define C8B_CYC_IMM 3'd2
`define C8B_CYC_DIR 3'd3
`define C8B_CYC_EXT 3'd4
`define C8B_CYC_IX  3'd3
`define C8B_CYC_IX1 3'd4
`define C8B_CYC_IX2 3'd5
`define C8B_CYC_REL 3'd3
`define C8B_CYC_BAD 3'd2

// ****************************************
// condition code bits and reset values
// ****************************************
`define C8B_CCR_H 4
`define C8B_CCR_I 3
`define C8B_CCR_N 2
`define C8B_CCR_Z 1
`define C8B_CCR_C 0
`define C8B_CCR_RST 5'h08
`define C8B_PC_RST  16'h0100
`define C8B_ACC_RST 8'h00
`define C8B_IDX_RST 8'h00

`endif

// *** pkg/c8b_pkg.sv ***
`include "c8b_params.svh"

package c8b_pkg;

  typedef enum logic [1:0] {
    AOP_ADC = 2'd0,
    AOP_SBC = 2'd1,
    AOP_EOR = 2'd2,
    AOP_BIT = 2'd3
  } c8b_aop_t;

  typedef enum logic [2:0] {
    M_IMM = 3'd0,
    M_DIR = 3'd1,
    M_EXT = 3'd2,
    M_IX  = 3'd3,
    M_IX1 = 3'd4,
    M_IX2 = 3'd5,
    M_REL = 3'd6
  } c8b_mode_t;

  // gray codes along the fetch path
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_OP   = 3'b001,
    ST_B1   = 3'b011,
    ST_B2   = 3'b010,
    ST_DATA = 3'b110,
    ST_PAD  = 3'b111
  } c8b_state_t;

endpackage : c8b_pkg

// *** pkg/c8b_dec_if.sv ***
`timescale 1ns/100ps

interface c8b_dec_if;
  import c8b_pkg::*;
  logic [7:0] opcode;
  logic       legal;
  logic       is_br;
  c8b_aop_t   aop;
  c8b_mode_t  mode;
  logic [2:0] cycles;

  modport dec  (input opcode, output legal, is_br, aop, mode, cycles);
  modport core (output opcode, input legal, is_br, aop, mode, cycles);
endinterface : c8b_dec_if

// *** verilog/c8b_decode.sv ***
`timescale 1ns/100ps
`include "c8b_params.svh"

module c8b_decode
  import c8b_pkg::*;
(
  c8b_dec_if.dec dif
);

  logic [3:0] hi_n;
  logic [3:0] lo_n;
  logic       arith;

  assign hi_n = dif.opcode[7:4];
  assign lo_n = dif.opcode[3:0];

  always_comb begin
    arith      = (lo_n == `C8B_LO_ADC) || (lo_n == `C8B_LO_SBC) ||
                 (lo_n == `C8B_LO_EOR) || (lo_n == `C8B_LO_BIT);
    dif.legal  = 1'b0;
    dif.is_br  = 1'b0;
    dif.aop    = AOP_ADC;
    dif.mode   = M_IMM;
    dif.cycles = `C8B_CYC_BAD;
    case (lo_n)
      `C8B_LO_SBC: dif.aop = AOP_SBC;
      `C8B_LO_EOR: dif.aop = AOP_EOR;
      `C8B_LO_BIT: dif.aop = AOP_BIT;
      default:     dif.aop = AOP_ADC;
    endcase
    if (arith && hi_n == `C8B_ROW_IMM) begin
      dif.legal = 1'b1; dif.mode = M_IMM; dif.cycles = `C8B_CYC_IMM;
    end else if (arith && hi_n == `C8B_ROW_DIR) begin
      dif.legal = 1'b1; dif.mode = M_DIR; dif.cycles = `C8B_CYC_DIR;
    end else if (arith && hi_n == `C8B_ROW_EXT) begin
      dif.legal = 1'b1; dif.mode = M_EXT; dif.cycles = `C8B_CYC_EXT;
    end else if (arith && hi_n == `C8B_ROW_IX) begin
      dif.legal = 1'b1; dif.mode = M_IX; dif.cycles = `C8B_CYC_IX;
    end else if (arith && hi_n == `C8B_ROW_IX1) begin
      dif.legal = 1'b1; dif.mode = M_IX1; dif.cycles = `C8B_CYC_IX1;
    end else if (arith && hi_n == `C8B_ROW_IX2) begin
      dif.legal = 1'b1; dif.mode = M_IX2; dif.cycles = `C8B_CYC_IX2;
    end else if (dif.opcode == `C8B_OP_LOWER_SAME || dif.opcode == `C8B_OP_CARRY_CLEAR ||
                 dif.opcode == `C8B_OP_CARRY_SET || dif.opcode == `C8B_OP_HCARRY_CLEAR ||
                 dif.opcode == `C8B_OP_HCARRY_SET || dif.opcode == `C8B_OP_MASK_CLEAR ||
                 dif.opcode == `C8B_OP_MASK_SET || dif.opcode == `C8B_OP_IRQ_LOW ||
                 dif.opcode == `C8B_OP_IRQ_HIGH) begin
      dif.legal = 1'b1; dif.is_br = 1'b1; dif.mode = M_REL; dif.cycles = `C8B_CYC_REL;
    end
  end

endmodule : c8b_decode

// *** verilog/c8b_alu.sv ***
`timescale 1ns/100ps
`include "c8b_params.svh"

module c8b_alu
  import c8b_pkg::*;
(
  input  wire c8b_aop_t   aop,
  input  wire logic [7:0] a,
  input  wire logic [7:0] m,
  input  wire logic [4:0] ccr_in,
  output logic      [7:0] res,
  output logic      [4:0] ccr_out
);

  logic [8:0] sum;
  logic [7:0] r;

  always_comb begin
    ccr_out = ccr_in;
    sum     = 9'h000;
    r       = 8'h00;
    res     = a;
    case (aop)
      AOP_ADC: begin
        sum = {1'b0, a} + {1'b0, m} + {8'h00, ccr_in[`C8B_CCR_C]};
        r   = sum[7:0];
        res = r;
        ccr_out[`C8B_CCR_C] = sum[8];
        // carry from bit 3 into bit 4
        ccr_out[`C8B_CCR_H] = (a[3] & m[3]) | (m[3] & ~r[3]) | (~r[3] & a[3]);
      end
      AOP_SBC: begin
        r   = a - m - {7'h00, ccr_in[`C8B_CCR_C]};
        res = r;
        ccr_out[`C8B_CCR_C] = (~a[7] & m[7]) | (m[7] & r[7]) | (r[7] & ~a[7]);
      end
      AOP_EOR: begin
        r   = a ^ m;
        res = r;
      end
      default: begin
        r   = a & m;
        res = a;
      end
    endcase
    ccr_out[`C8B_CCR_N] = r[7];
    ccr_out[`C8B_CCR_Z] = (r == 8'h00);
  end

endmodule : c8b_alu

// *** verif/c8b_mem_model.sv ***
`timescale 1ns/100ps

module c8b_mem_model (
  // clock
  input  wire logic        clk,
  // read port
  input  wire logic [15:0] addr,
  input  wire logic        rd,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  // unwritten bytes hold an opcode the core does not handle
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h9D;
    end
    last_r = 8'h00;
  end

  always @(posedge clk) begin
    if (rd) begin
      last_r <= mem[addr];
    end
  end

  // no wait states; an idle bus shows the inverse so stale data never matches
  assign rdata = rd ? mem[addr] : ~last_r;
endmodule : c8b_mem_model

// *** verif/tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
  logic        CLK;
  logic        RST_N;
  logic [15:0] MEM_ADDR;
  logic        MEM_RD;
  logic [7:0]  MEM_RDATA;
  logic        IRQ_N;
  logic        IRQ_ACK;
  logic        IRQ_REQ;
  logic        LD_IDX_WR;
  logic        LD_CCR_WR;
  logic [7:0]  LD_DATA;
  logic [7:0]  ACC;
  logic [7:0]  IDX;
  logic [4:0]  CCR;
  logic [15:0] PC;
  logic        INSTR_DONE;
  logic        ILLEGAL;
  int          error_cnt;
  int          samples_checked;
  logic [7:0]  acc_m;
  logic [4:0]  ccr_m;

  c8b_core dut_u (
    .CLK(CLK), .RST_N(RST_N), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA),
    .IRQ_N(IRQ_N), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .LD_IDX_WR(LD_IDX_WR),
    .LD_CCR_WR(LD_CCR_WR), .LD_DATA(LD_DATA), .ACC(ACC), .IDX(IDX), .CCR(CCR), .PC(PC),
    .INSTR_DONE(INSTR_DONE), .ILLEGAL(ILLEGAL)
  );

  c8b_mem_model mem_u (.clk(CLK), .addr(MEM_ADDR), .rd(MEM_RD), .rdata(MEM_RDATA));

  always #5 CLK = ~CLK;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step();
    @(posedge CLK);
    #1;
  endtask : step

  // entered in cycle 0 of an instruction, left in cycle 0 of the next
  task automatic run(input logic [7:0] op, b1, b2, input int cyc, input logic [15:0] adv);
    int          n;
    logic [15:0] a;
    a = MEM_ADDR;
    mem_u.mem[a] = op;
    mem_u.mem[a + 16'h0001] = b1;
    mem_u.mem[a + 16'h0002] = b2;
    n = 0;
    do begin
      step();
      LD_CCR_WR = 1'b0;
      LD_IDX_WR = 1'b0;
      IRQ_ACK = 1'b0;
      if (n == 0) begin
        chk("illegal", 32'(op == 8'h9D), 32'(ILLEGAL));
      end
      n++;
    end while (INSTR_DONE !== 1'b1 && n < 20);
    chk("cycles", 32'(cyc), 32'(n));
    chk("next_opcode_addr", 32'(16'(a + adv)), 32'(MEM_ADDR));
    chk("pc", 32'(16'(a + adv + 16'h0001)), 32'(PC));
  endtask : run

  task automatic set_ccr(input logic [4:0] v);
    LD_DATA = {3'b000, v};
    LD_CCR_WR = 1'b1;
    ccr_m = v;
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
  endtask : set_ccr

  function automatic logic [12:0] alu(input logic [3:0] lo, input logic [7:0] a, m,
                                      input logic [4:0] c);
    logic [8:0] s;
    logic       h;
    h = c[4];
    case (lo)
      4'h9: begin
        s = {1'b0, a} + {1'b0, m} + {8'h00, c[0]};
        h = ({1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c[0]}) > 5'h0F;
      end
      4'h2: s = {1'b0, a} - {1'b0, m} - {8'h00, c[0]};
      4'h8: s = {c[0], a ^ m};
      default: s = {c[0], a & m};
    endcase
    return {h, c[3], s[7], s[7:0] == 8'h00, s[8], (lo == 4'h5) ? a : s[7:0]};
  endfunction : alu

  function automatic logic br_take(input logic [7:0] op, input logic [4:0] c, input logic ln);
    case (op)
      8'h23: return c[0] | c[1];
      8'h24: return !c[0];
      8'h25: return c[0];
      8'h28: return !c[4];
      8'h29: return c[4];
      8'h2C: return !c[3];
      8'h2D: return c[3];
      8'h2E: return !ln;
      default: return ln;
    endcase
  endfunction : br_take

  task automatic branch(input logic [7:0] op, input logic [7:0] disp);
    run(op, disp, 8'h00, 3,
        br_take(op, ccr_m, IRQ_N) ? 16'h0002 + {{8{disp[7]}}, disp} : 16'h0002);
  endtask : branch

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    repeat (5) step();
    chk("reset_state", {7'h00, 1'b0, 5'h08, 16'h0100, 3'b000},
        {7'h00, MEM_RD, CCR, PC, IRQ_REQ, INSTR_DONE, ILLEGAL});
    chk("reset_acc", 32'h0000_0000, 32'(ACC));
    chk("reset_idx_addr", 32'h0000_0000, {8'h00, IDX, MEM_ADDR});
    RST_N = 1'b1;
    step();
    chk("boot_read", {15'h0000, 1'b1, 16'h0100}, {15'h0000, MEM_RD, MEM_ADDR});
    chk("boot_pc", 32'h0000_0101, 32'(PC));
  endtask : test_reset

  task automatic test_arith();
    logic [3:0]  rows[6] = '{4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD};
    logic [3:0]  ops[4] = '{4'h9, 4'h2, 4'h8, 4'h5};
    logic [7:0]  b1s[6] = '{8'h00, 8'h40, 8'h02, 8'h00, 8'h00, 8'h02};
    logic [7:0]  b2s[6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    int          cyc[6] = '{2, 3, 4, 3, 4, 5};
    int          len[6] = '{2, 2, 3, 1, 2, 3};
    logic [7:0]  m;
    logic [12:0] e;
    LD_DATA = 8'h40;
    LD_IDX_WR = 1'b1;
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
    chk("idx", 32'h0000_0040, 32'(IDX));
    set_ccr(5'h01);
    foreach (ops[o]) begin
      for (int r = 0; r < 6; r++) begin
        m = 8'(91 * (o * 6 + r + 3));
        mem_u.mem[16'h0040] = m;
        mem_u.mem[16'h0240] = m;
        e = alu(ops[o], acc_m, m, ccr_m);
        run({rows[r], ops[o]}, (r == 0) ? m : b1s[r], b2s[r], cyc[r], 16'(len[r]));
        {ccr_m, acc_m} = e;
        chk("acc", 32'(acc_m), 32'(ACC));
        chk("ccr", 32'(ccr_m), 32'(CCR));
      end
    end
  endtask : test_arith

  task automatic test_half_carry();
    set_ccr(5'h00);
    run(8'hA8, acc_m ^ 8'h0F, 8'h00, 2, 16'h0002);
    run(8'hA9, 8'h01, 8'h00, 2, 16'h0002);
    chk("acc", 32'h0000_0010, 32'(ACC));
    chk("ccr", 32'h0000_0010, 32'(CCR));
    acc_m = 8'h10;
    ccr_m = 5'h10;
  endtask : test_half_carry

  task automatic test_branches();
    logic [7:0] bops[7] = '{8'h23, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2C, 8'h2D};
    logic [4:0] cc[3] = '{5'h00, 5'h1F, 5'h02};
    foreach (bops[i]) begin
      foreach (cc[j]) begin
        set_ccr(cc[j]);
        branch(bops[i], j[0] ? 8'hFA : 8'h05);
      end
    end
  endtask : test_branches

  task automatic test_irq_line();
    set_ccr(5'h08);
    IRQ_N = 1'b0;
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
    branch(8'h2E, 8'h06);
    branch(8'h2F, 8'h06);
    IRQ_N = 1'b1;
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
    branch(8'h2E, 8'h06);
    branch(8'h2F, 8'h06);
    chk("irq_req_masked", 32'h0000_0000, 32'(IRQ_REQ));
    set_ccr(5'h00);
    chk("irq_req_unmasked", 32'h0000_0001, 32'(IRQ_REQ));
    IRQ_ACK = 1'b1;
    run(8'h9D, 8'h00, 8'h00, 2, 16'h0001);
    chk("irq_req_acked", 32'h0000_0000, 32'(IRQ_REQ));
  endtask : test_irq_line

  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    CLK = 1'b0;
    RST_N = 1'b0;
    IRQ_N = 1'b1;
    IRQ_ACK = 1'b0;
    LD_IDX_WR = 1'b0;
    LD_CCR_WR = 1'b0;
    LD_DATA = 8'h00;
    error_cnt = 0;
    samples_checked = 0;
    acc_m = 8'h00;
    ccr_m = 5'h08;
    test_reset();
    test_arith();
    test_half_carry();
    test_branches();
    test_irq_line();
    test_done();
  end
endmodule : tb_top
